/* File: design/shu_pkg.sv */
// shared constants and types for the serial-host uart port
// assumes a single 20 MHz system clock; all host pins are asynchronous to it
package shu_pkg;

   // host word framing
   localparam int         WORD_W        = 16;
   localparam logic [4:0] WORD_BITS     = 5'h10;   // clocks per selection
   localparam logic [1:0] OP_WR_CFG_DEF = 2'h3;
   localparam logic [1:0] OP_RD_CFG_DEF = 2'h1;
   localparam logic [1:0] OP_WR_DAT_DEF = 2'h2;
   localparam logic [1:0] OP_RD_DAT_DEF = 2'h0;

   // field positions inside the 16-bit word
   localparam int R_BIT     = 15;  // receive data available
   localparam int T_BIT     = 14;  // transmit buffer empty
   localparam int BAUD_LSB  = 0;
   localparam int LEN_BIT   = 4;
   localparam int PE_BIT    = 5;
   localparam int ST_BIT    = 6;
   localparam int IR_BIT    = 7;
   localparam int RTS_BIT   = 8;
   localparam int CTS_BIT   = 9;
   localparam int FEN_BIT   = 10;
   localparam int DATA_LSB  = 0;
   localparam int EXTRA_BIT = 8;
   localparam int FE_BIT    = 11;

   // reset values
   localparam logic [3:0] BAUD_RST = 4'h0;
   localparam logic       FEN_RST  = 1'h0;

   // sizes and timing
   localparam int FIFO_DEPTH   = 8;
   localparam int BIT_BASE_DEF = 4;   // system cycles per bit at divisor 0
   localparam int CNT_W        = 20;

   typedef struct packed {
      logic [3:0] baud;
      logic       len7;
      logic       pe;
      logic       st2;
      logic       ir;
      logic       rts;
      logic       fen_n;
   } shu_cfg_t;

   typedef enum logic [5:0] {
      TX_IDLE  = 6'h01,
      TX_START = 6'h02,
      TX_DATA  = 6'h04,
      TX_EXTRA = 6'h08,
      TX_STOP1 = 6'h10,
      TX_STOP2 = 6'h20
   } shu_tx_state_t;

   typedef enum logic [4:0] {
      RX_IDLE  = 5'h01,
      RX_START = 5'h02,
      RX_DATA  = 5'h04,
      RX_EXTRA = 5'h08,
      RX_STOP  = 5'h10
   } shu_rx_state_t;

endpackage

/* File: design/shu_rx.sv */
// asynchronous character receiver with optional infrared pulse decoding
// assumes rx_pin is raw from a pin; it is synchronised here
module shu_rx
   import shu_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic reset,
   shu_rx_if.rcv     lnk
);

   typedef struct packed {
      logic [1:0]       sync;
      shu_rx_state_t    st;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] hold;
      logic [3:0]       bits;
      logic [7:0]       data;
      logic             extra;
      logic             valid;
      logic             ferr;
   } shu_rx_st_t;

   shu_rx_st_t s_reg;
   shu_rx_st_t s_next;
   logic       level;
   logic [3:0] nbits;

   // line decode, bit timing and framing
   always_comb begin
      s_next       = s_reg;
      s_next.sync  = {s_reg.sync[0], lnk.rx_pin};
      s_next.valid = 1'h0;
      s_next.ferr  = 1'h0;
      if (lnk.ir && s_reg.sync[1])  // pulse stretch for infrared zeros
         s_next.hold = lnk.period >> 1;
      else if (s_reg.hold != '0)
         s_next.hold = s_reg.hold - CNT_W'(1);
      level = lnk.ir ? ~(s_reg.sync[1] | (s_reg.hold != '0)) : s_reg.sync[1];
      nbits = lnk.len7 ? 4'h7 : 4'h8;
      s_next.cnt = s_reg.cnt + CNT_W'(1);
      case (s_reg.st)
         RX_IDLE: begin
            s_next.cnt = '0;
            if (!level)
               s_next.st = RX_START;
         end
         RX_START: begin
            if (s_reg.cnt == (lnk.period >> 1)) begin
               s_next.cnt  = '0;
               s_next.bits = 4'h0;
               s_next.st   = level ? RX_IDLE : RX_DATA;
            end
         end
         RX_DATA: begin
            if (s_reg.cnt == lnk.period - CNT_W'(1)) begin
               s_next.cnt  = '0;
               s_next.data = {level, s_reg.data[7:1]};
               s_next.bits = s_reg.bits + 4'h1;
               if (s_reg.bits == nbits - 4'h1)
                  s_next.st = lnk.pe ? RX_EXTRA : RX_STOP;
            end
         end
         RX_EXTRA: begin
            if (s_reg.cnt == lnk.period - CNT_W'(1)) begin
               s_next.cnt   = '0;
               s_next.extra = level;
               s_next.st    = RX_STOP;
            end
         end
         RX_STOP: begin
            if (s_reg.cnt == lnk.period - CNT_W'(1)) begin
               s_next.valid = level;
               s_next.ferr  = ~level;
               s_next.st    = RX_IDLE;
               if (!lnk.pe)
                  s_next.extra = 1'h0;
            end
         end
         default: s_next.st = RX_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s_reg      <= '0;
         s_reg.sync <= 2'h3;
         s_reg.st   <= RX_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   // seven-bit characters arrive one place high in the shifter
   assign lnk.char_valid = s_reg.valid;
   assign lnk.frame_err  = s_reg.ferr;
   assign lnk.char_data  = lnk.len7 ? {1'h0, s_reg.data[7:1]} : s_reg.data;
   assign lnk.char_extra = s_reg.extra;

endmodule

/* File: design/shu_rx_if.sv */
// carrier between the port top and its asynchronous receiver
// assumes both ends run on clk_sys
interface shu_rx_if
   import shu_pkg::*;
();
   logic             rx_pin;
   logic [CNT_W-1:0] period;
   logic             len7;
   logic             pe;
   logic             ir;
   logic             char_valid;
   logic [7:0]       char_data;
   logic             char_extra;
   logic             frame_err;

   modport top (output rx_pin, period, len7, pe, ir,
                input  char_valid, char_data, char_extra, frame_err);
   modport rcv (input  rx_pin, period, len7, pe, ir,
                output char_valid, char_data, char_extra, frame_err);
endinterface

/* File: design/shu_top.sv */
// serial-host uart port: 16-bit full-duplex host word port, receive fifo,
// transmitter with extra bit and infrared timing, modem handshake pins
// assumes cs_n, sclk, din, rx and cts_n are asynchronous pins
module shu_top
   import shu_pkg::*;
#(
   parameter int         BIT_BASE  = BIT_BASE_DEF,
   parameter int         DEPTH     = FIFO_DEPTH,
   parameter logic [1:0] OP_WR_CFG = OP_WR_CFG_DEF,
   parameter logic [1:0] OP_RD_CFG = OP_RD_CFG_DEF,
   parameter logic [1:0] OP_WR_DAT = OP_WR_DAT_DEF,
   parameter logic [1:0] OP_RD_DAT = OP_RD_DAT_DEF
)(
   input  wire logic clk_sys,
   input  wire logic reset,
   input  wire logic cs_n,
   input  wire logic sclk,
   input  wire logic din,
   output wire logic dout,
   output wire logic dout_oe,
   input  wire logic rx,
   output wire logic tx,
   input  wire logic cts_n,
   output wire logic rts_n
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [2:0]                cs_s;
      logic [2:0]                sclk_s;
      logic [1:0]                din_s;
      logic [1:0]                cts_s;
      logic [4:0]                cnt;
      logic [1:0]                op;
      logic [WORD_W-1:0]         rx_word;
      logic [8:0]                snap;
      logic                      snap_r;
      logic                      dout;
      logic                      dout_oe;
      logic                      rts_n;
      logic                      tx;
      shu_cfg_t                  cfg;
      logic                      fe;
      logic [DEPTH-1:0][8:0]     mem;
      logic [AW-1:0]             rd;
      logic [AW-1:0]             wr;
      logic [AW:0]               count;
      logic [8:0]                tbuf;
      logic                      tfull;
      shu_tx_state_t             txs;
      logic [7:0]                tsh;
      logic                      textra;
      logic [3:0]                tbits;
      logic [CNT_W-1:0]          tcnt;
   } shu_top_st_t;

   shu_top_st_t       r_reg;
   shu_top_st_t       r_next;
   shu_top_st_t       rst_v;
   logic [WORD_W-1:0] word;
   logic              cs_fall;
   logic              cs_rise;
   logic              cs_low;
   logic              sclk_rise;
   logic              sclk_fall;
   logic              data_op;
   logic              push;
   logic              pop;
   logic [AW:0]       cap;
   logic [CNT_W-1:0]  period;
   logic [CNT_W-1:0]  irlen;
   logic              tick;
   logic              lv;
   logic [3:0]        nbits;
   logic [4:0]        oidx;

   shu_rx_if lnk ();

   shu_rx u_rx (
      .clk_sys (clk_sys),
      .reset   (reset),
      .lnk     (lnk)
   );

   // receiver configuration
   assign lnk.rx_pin = rx;
   assign lnk.period = period;
   assign lnk.len7   = r_reg.cfg.len7;
   assign lnk.pe     = r_reg.cfg.pe;
   assign lnk.ir     = r_reg.cfg.ir;

   // pin edge detection on the second and third sync stages
   assign cs_fall   = r_reg.cs_s[2] & ~r_reg.cs_s[1];
   assign cs_rise   = ~r_reg.cs_s[2] & r_reg.cs_s[1];
   assign cs_low    = ~r_reg.cs_s[1];
   assign sclk_rise = ~r_reg.sclk_s[2] & r_reg.sclk_s[1];
   assign sclk_fall = r_reg.sclk_s[2] & ~r_reg.sclk_s[1];
   assign data_op   = (r_reg.op == OP_WR_DAT) || (r_reg.op == OP_RD_DAT);

   // bit timing derived from the divisor select
   assign period = CNT_W'(BIT_BASE) << r_reg.cfg.baud;
   assign irlen  = ((period >> 3) + (period >> 4) == '0) ? CNT_W'(1)
                                                         : (period >> 3) + (period >> 4);
   assign tick   = r_reg.tcnt == period - CNT_W'(1);
   assign nbits  = r_reg.cfg.len7 ? 4'h7 : 4'h8;
   assign cap    = r_reg.cfg.fen_n ? (AW+1)'(1) : (AW+1)'(DEPTH);
   assign oidx   = 5'hF - r_reg.cnt;

   // outgoing word, operation dependent below the two status bits except the clear-to-send bit
   always_comb begin
      word          = '0;
      word[R_BIT]   = r_reg.snap_r;
      word[T_BIT]   = ~r_reg.tfull;
      word[CTS_BIT] = ~r_reg.cts_s[1];
      if (data_op) begin
         word[DATA_LSB +: 8] = {r_reg.snap[7] & ~r_reg.cfg.len7, r_reg.snap[6:0]};
         word[EXTRA_BIT]     = r_reg.snap[8];
         word[FE_BIT]        = r_reg.fe;
      end else begin
         word[BAUD_LSB +: 4] = r_reg.cfg.baud;
         word[LEN_BIT]       = r_reg.cfg.len7;
         word[PE_BIT]        = r_reg.cfg.pe;
         word[ST_BIT]        = r_reg.cfg.st2;
         word[IR_BIT]        = r_reg.cfg.ir;
         word[RTS_BIT]       = r_reg.cfg.rts;
         word[FEN_BIT]       = r_reg.cfg.fen_n;
      end
   end

   // transmit line level by state
   always_comb begin
      case (r_reg.txs)
         TX_START: lv = 1'h0;
         TX_DATA:  lv = r_reg.tsh[0];
         TX_EXTRA: lv = r_reg.textra;
         default:  lv = 1'h1;
      endcase
   end

   // reset image of the state
   always_comb begin
      rst_v         = '0;
      rst_v.cs_s    = 3'h7;
      rst_v.sclk_s  = 3'h0;
      rst_v.rts_n   = 1'h1;
      rst_v.tx      = 1'h1;
      rst_v.cfg.baud  = BAUD_RST;
      rst_v.cfg.fen_n = FEN_RST;
      rst_v.txs     = TX_IDLE;
   end

   // host port, fifo, transmitter
   always_comb begin
      r_next        = r_reg;
      r_next.cs_s   = {r_reg.cs_s[1:0], cs_n};
      r_next.sclk_s = {r_reg.sclk_s[1:0], sclk};
      r_next.din_s  = {r_reg.din_s[0], din};
      r_next.cts_s  = {r_reg.cts_s[0], cts_n};
      r_next.rts_n  = ~r_reg.cfg.rts;
      pop  = 1'h0;
      push = 1'h0;
      // host word shifting
      if (cs_fall) begin
         r_next.cnt     = 5'h0;
         r_next.snap    = r_reg.mem[r_reg.rd];
         r_next.snap_r  = r_reg.count != '0;
         r_next.dout    = r_reg.count != '0;
         r_next.dout_oe = 1'h1;
      end else if (cs_low) begin
         if (sclk_rise && r_reg.cnt < WORD_BITS) begin
            r_next.rx_word = {r_reg.rx_word[WORD_W-2:0], r_reg.din_s[1]};
            r_next.cnt     = r_reg.cnt + 5'h1;
            if (r_reg.cnt == 5'h1)
               r_next.op = {r_reg.rx_word[0], r_reg.din_s[1]};
         end
         if (sclk_fall && r_reg.cnt != 5'h0 && r_reg.cnt < WORD_BITS)
            r_next.dout = word[oidx[3:0]];
         if (sclk_fall && r_reg.cnt == WORD_BITS && data_op && r_reg.snap_r)
            pop = 1'h1;
      end
      // commit only complete words
      if (cs_rise) begin
         r_next.dout_oe = 1'h0;
         if (r_reg.cnt == WORD_BITS) begin
            if (r_reg.op == OP_WR_CFG) begin
               r_next.cfg.baud  = r_reg.rx_word[BAUD_LSB +: 4];
               r_next.cfg.len7  = r_reg.rx_word[LEN_BIT];
               r_next.cfg.pe    = r_reg.rx_word[PE_BIT];
               r_next.cfg.st2   = r_reg.rx_word[ST_BIT];
               r_next.cfg.ir    = r_reg.rx_word[IR_BIT];
               r_next.cfg.rts   = r_reg.rx_word[RTS_BIT];
               r_next.cfg.fen_n = r_reg.rx_word[FEN_BIT];
               r_next.fe        = 1'h0;
            end else if (r_reg.op == OP_WR_DAT && !r_reg.tfull) begin
               r_next.tbuf  = {r_reg.rx_word[EXTRA_BIT], r_reg.rx_word[DATA_LSB +: 8]};
               r_next.tfull = 1'h1;
            end
         end
      end
      // framing error flag, a new event wins over the clear
      if (lnk.char_valid)
         r_next.fe = 1'h0;
      if (lnk.frame_err)
         r_next.fe = 1'h1;
      // receive fifo
      if (pop) begin
         r_next.rd = (r_reg.rd == AW'(DEPTH-1)) ? '0 : r_reg.rd + AW'(1);
      end
      if (lnk.char_valid && r_reg.count < cap) begin
         push = 1'h1;
         r_next.mem[r_reg.wr] = {lnk.char_extra, lnk.char_data};
         r_next.wr = (r_reg.wr == AW'(DEPTH-1)) ? '0 : r_reg.wr + AW'(1);
      end
      r_next.count = r_reg.count + (AW+1)'(push) - (AW+1)'(pop);
      // transmitter
      r_next.tcnt = tick ? '0 : r_reg.tcnt + CNT_W'(1);
      case (r_reg.txs)
         TX_IDLE: begin
            r_next.tcnt = '0;
            if (r_reg.tfull && !cs_rise) begin
               r_next.tsh    = {r_reg.tbuf[7] & ~r_reg.cfg.len7, r_reg.tbuf[6:0]};
               r_next.textra = r_reg.tbuf[8];
               r_next.tfull  = 1'h0;
               r_next.tbits  = 4'h0;
               r_next.txs    = TX_START;
            end
         end
         TX_START: if (tick) r_next.txs = TX_DATA;
         TX_DATA: begin
            if (tick) begin
               r_next.tsh   = r_reg.tsh >> 1;
               r_next.tbits = r_reg.tbits + 4'h1;
               if (r_reg.tbits == nbits - 4'h1)
                  r_next.txs = r_reg.cfg.pe ? TX_EXTRA : TX_STOP1;
            end
         end
         TX_EXTRA: if (tick) r_next.txs = TX_STOP1;
         TX_STOP1: if (tick) r_next.txs = r_reg.cfg.st2 ? TX_STOP2 : TX_IDLE;
         TX_STOP2: if (tick) r_next.txs = TX_IDLE;
         default:  r_next.txs = TX_IDLE;
      endcase
      // infrared sends a short high pulse for each zero
      r_next.tx = r_reg.cfg.ir ? (~lv & (r_reg.tcnt < irlen)) : lv;
   end

   // state register; clear-to-send sampling is untouched by reset
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         r_reg       <= rst_v;
         r_reg.cts_s <= r_next.cts_s;
      end else begin
         r_reg <= r_next;
      end
   end

   assign dout    = r_reg.dout;
   assign dout_oe = r_reg.dout_oe;
   assign tx      = r_reg.tx;
   assign rts_n   = r_reg.rts_n;

   // checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   sel_start_a: assert property (cs_fall |=> r_reg.dout_oe && r_reg.cnt == 5'h0)
      else $error("select fall did not restart the word");
   out_shift_a: assert property (cs_low && sclk_fall && r_reg.cnt != 5'h0
                                 && r_reg.cnt < WORD_BITS |=> r_reg.dout == $past(word[oidx[3:0]]))
      else $error("output bit not presented on serial clock fall");
   in_sample_a: assert property (cs_low && sclk_rise && r_reg.cnt < WORD_BITS
                                 |=> r_reg.rx_word[0] == $past(r_reg.din_s[1]))
      else $error("input bit not sampled on rise");
   short_word_a: assert property (cs_rise && r_reg.cnt != WORD_BITS |=> $stable(r_reg.cfg))
      else $error("aborted word changed configuration");
   cfg_commit_a: assert property (cs_rise && r_reg.cnt == WORD_BITS && r_reg.op == OP_WR_CFG
                   |=> r_reg.cfg.baud == $past(r_reg.rx_word[BAUD_LSB +: 4]))
      else $error("configuration write not committed");
   cts_bit_a: assert property (r_reg.cts_s[1] |-> !word[CTS_BIT])
      else $error("clear-to-send bit not inverted pin");
   rts_pin_a: assert property ($rose(r_reg.cfg.rts) |=> !r_reg.rts_n)
      else $error("request-to-send pin not inverted bit");
   // a disable written while several characters wait leaves them readable, so only new
   // characters are held against the current capacity
   fifo_cap_a: assert property (push |-> r_reg.count < cap)
      else $error("receive fifo pushed beyond its capacity");
   avail_drop_a: assert property (pop && r_reg.count == (AW+1)'(1) && !push
                                  |=> r_reg.count == '0)
      else $error("available flag did not drop on final fall");
   stop_one_a: assert property (r_reg.txs == TX_STOP1 && tick && !r_reg.cfg.st2
                                |=> r_reg.txs == TX_IDLE)
      else $error("extra stop bit sent with one-stop select");
   start_low_a: assert property (r_reg.txs == TX_START && !r_reg.cfg.ir |=> !r_reg.tx)
      else $error("start bit not low");

   cfg_write_c: cover property (cs_rise && r_reg.cnt == WORD_BITS && r_reg.op == OP_WR_CFG);
   data_write_c: cover property (cs_rise && r_reg.cnt == WORD_BITS && r_reg.op == OP_WR_DAT);
   fifo_full_c: cover property (r_reg.count == (AW+1)'(DEPTH));
   frame_err_c: cover property (lnk.frame_err);

endmodule

/* File: tb/shu_host_model.sv */
// host-side model: synchronous serial master, clock idle low, 16-bit words
// assumes clk_sys paces it; sclk half period is four clk_sys cycles
module shu_host_model (
   input  wire logic clk_sys,
   output logic      cs_n,
   output logic      sclk,
   output logic      din,
   input  wire logic dout,
   input  wire logic dout_oe
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [15:0] rbuf;
   event        done;

   // idle levels before the first selection
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din  = 1'b0;
      rbuf = 16'h0000;
   end

   // one selection of n clocks; fewer than sixteen aborts the word
   task automatic xfer(input logic [15:0] w, input int n);
      @(posedge clk_sys);
      cs_n <= 1'b0;
      din  <= w[15];
      repeat (4) @(posedge clk_sys);
      for (int i = 0; i < n; i++) begin
         sclk <= 1'b1;
         rbuf = {rbuf[14:0], dout_oe ? dout : 1'bx};
         repeat (4) @(posedge clk_sys);
         sclk <= 1'b0;
         if (i < 15) din <= w[14-i];
         repeat (4) @(posedge clk_sys);
      end
      cs_n <= 1'b1;
      din  <= ~din; // released line shows the inverse
      repeat (5) @(posedge clk_sys);
      -> done;
   endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench for the serial-host uart port
// assumes the host model drives the word port; the bench plays the far uart
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import shu_pkg::*;

   localparam int BT = 8; // cycles per bit at divisor 0

   logic        clk_sys = 1'b0;
   logic        reset   = 1'b1;
   logic        rx      = 1'b1;
   logic        cts_n   = 1'b1;
   logic        cs_n, sclk, din, dout, dout_oe, tx, rts_n;
   int          n_errors  = 0;
   int          tests_run = 0;
   int          seed      = 32'h3CFB;
   int          bt        = BT;
   logic [31:0] exp_q[$];
   logic [31:0] tx_q[$];
   logic [31:0] e, t;
   logic [15:0] got, w;
   logic [7:0]  b[9];
   logic        x[9];
   logic        cn;

   always #25 clk_sys = ~clk_sys;

   shu_host_model host (.clk_sys(clk_sys), .cs_n(cs_n), .sclk(sclk), .din(din),
                        .dout(dout), .dout_oe(dout_oe));

   shu_top #(.BIT_BASE(BT)) dut (.clk_sys(clk_sys), .reset(reset), .cs_n(cs_n),
      .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe), .rx(rx), .tx(tx),
      .cts_n(cts_n), .rts_n(rts_n));

   task chk_word(input logic [15:0] g, input logic [31:0] ex);
      tests_run++;
      if ((g & ex[31:16]) !== ex[15:0]) begin
         n_errors++;
         $display("mismatch at %0t got %h exp %h", $time, g & ex[31:16], ex[15:0]);
      end
   endtask

   task chk_tx(input logic [15:0] g, input logic [15:0] ex);
      tests_run++;
      if (g !== ex) begin
         n_errors++;
         $display("mismatch at %0t tx got %h exp %h", $time, g, ex);
      end
   endtask

   task summarize;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // one host word with its expected answer under a mask
   task op(input logic [15:0] wd, input int n, input logic [15:0] v, input logic [15:0] m);
      exp_q.push_back({m, v});
      host.xfer(wd, n);
   endtask

   // configuration write, then the request-to-send pin follows the bit
   task wcfg(input logic [15:0] c);
      op({OP_WR_CFG_DEF, c[13:0]}, 16, 16'h0000, 16'h0000);
      chk_word({15'h0, rts_n}, {16'h0001, 15'h0, ~c[RTS_BIT]});
   endtask

   // far uart sends a frame lsb first, start bit included
   task send(input logic [10:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         rx <= f[i];
         repeat (BT) @(posedge clk_sys);
      end
      rx <= 1'b1;
      repeat (BT * 3) @(posedge clk_sys);
   endtask

   // answer watcher: oldest note against each finished word
   always @(host.done) begin
      e = exp_q.pop_front();
      chk_word(host.rbuf, e);
   end

   // tx watcher: samples each bit mid-cell after a start edge
   always begin
      wait (tx_q.size() > 0);
      while (tx !== 1'b0) @(posedge clk_sys);
      repeat (bt / 2) @(posedge clk_sys);
      t   = tx_q.pop_front();
      got = 16'h0000;
      for (int i = 0; i < t[23:16]; i++) begin
         repeat (bt) @(posedge clk_sys);
         got[i] = tx;
      end
      chk_tx(got, t[15:0]);
   end

   // watchdog cuts a hang
   initial begin
      repeat (40000) @(posedge clk_sys);
      n_errors++;
      summarize;
   end

   initial begin
      cts_n = $random(seed);
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (4) @(posedge clk_sys);
      op({OP_RD_CFG_DEF, 14'h0}, 16, {6'h0, ~cts_n, 9'h0}, 16'h07FF);
      // random settings read back with the inverted clear-to-send pin
      for (int i = 0; i < 4; i++) begin
         w  = $random(seed) & 16'h057F;
         cn = $random(seed);
         cts_n <= cn;
         wcfg(w);
         op({OP_RD_CFG_DEF, 14'h0}, 16, w | {6'h0, ~cn, 9'h0}, 16'h07FF);
      end
      op({OP_WR_CFG_DEF, 14'h3FFF}, 10, 16'h0000, 16'h0000);
      op({OP_RD_CFG_DEF, 14'h0}, 16, w | {6'h0, ~cn, 9'h0}, 16'h07FF);
      wcfg(16'h0160);
      repeat (9) op({OP_RD_DAT_DEF, 14'h0}, 16, 16'h0000, 16'h0000);
      // nine characters into an eight-deep queue, extra bit kept with each
      for (int i = 0; i < 9; i++) begin
         b[i] = $random(seed);
         x[i] = $random(seed);
         send({1'b1, x[i], b[i], 1'b0}, 11);
      end
      for (int i = 0; i < 8; i++)
         op({OP_RD_DAT_DEF, 14'h0}, 16, {7'h40, x[i], b[i]}, 16'h89FF);
      op({OP_WR_DAT_DEF, 14'h0}, 16, 16'h0000, 16'h8000);
      // zero stop bit flags an error, a configuration write clears it
      send({1'b0, x[0], b[0], 1'b0}, 11);
      op({OP_RD_DAT_DEF, 14'h0}, 16, 16'h0800, 16'h8800);
      wcfg(16'h0160);
      op({OP_RD_DAT_DEF, 14'h0}, 16, 16'h0000, 16'h8800);
      wcfg(16'h0110);
      send({2'b01, b[1][6:0], 1'b0}, 9);
      op({OP_RD_DAT_DEF, 14'h0}, 16, {9'h100, b[1][6:0]}, 16'h89FF);
      // two characters back to back, extra bit as written, two stops
      wcfg(16'h0161);
      bt = BT * 2;
      for (int i = 2; i < 4; i++) begin
         tx_q.push_back({8'h00, 8'd11, 5'h00, 2'b11, x[i], b[i]});
         op({OP_WR_DAT_DEF, 5'h0, x[i], b[i]}, 16, 16'h0000, 16'h0000);
      end
      wait (tx_q.size() == 0);
      // the queue empties at the start bit, so let the whole last frame go out
      repeat (BT * 32) @(posedge clk_sys);
      // seven bits, extra ignored, one stop
      wcfg(16'h0010);
      bt = BT;
      tx_q.push_back({8'h00, 8'd8, 8'h00, 1'b1, b[4][6:0]});
      op({OP_WR_DAT_DEF, 5'h0, 1'b1, 1'b1, b[4][6:0]}, 16, 16'h0000, 16'h0000);
      wait (tx_q.size() == 0);
      // the watcher still samples eight cells after the queue empties
      repeat (BT * 12) @(posedge clk_sys);
      summarize;
   end
endmodule
